// File: common/adcct_pkg.sv
// Constants, register map and state types for the converter timing block
package adcct_pkg;

    // Register byte offsets on the AXI4-Lite port
    localparam logic [7:0] ADCCT_OFF_CTRL    = 8'h00; // converter_control_register
    localparam logic [7:0] ADCCT_OFF_STATUS  = 8'h04; // Busy and calibration state
    localparam logic [7:0] ADCCT_OFF_RESULT  = 8'h08; // Conversion result
    localparam logic [7:0] ADCCT_OFF_SYSCFG  = 8'h0C; // system_config_one
    localparam logic [7:0] ADCCT_OFF_MCGEN   = 8'h10; // master_clock_generator_control
    localparam logic [7:0] ADCCT_OFF_IMPDIV  = 8'h14; // Improved-mode divider

    // Control register field positions
    localparam int ADCCT_CTRL_START_BIT  = 0;  // Write 1 starts a conversion
    localparam int ADCCT_CTRL_RES8_BIT   = 1;  // 1 selects 8-bit resolution
    localparam int ADCCT_CTRL_NOPC_BIT   = 2;  // 1 switches post-calibration off
    localparam int ADCCT_CTRL_IMPR_BIT   = 3;  // 1 selects improved clock control
    localparam int ADCCT_CTRL_STC_LSB    = 12; // sample_time_select low bit
    localparam int ADCCT_CTRL_CTC_LSB    = 14; // basic_clock_divider_select low bit

    // Status register field positions
    localparam int ADCCT_STAT_BUSY_BIT   = 0;
    localparam int ADCCT_STAT_CAL_BIT    = 1;
    localparam int ADCCT_STAT_VALID_BIT  = 2;

    // Reset values
    localparam logic [15:0] ADCCT_CTRL_RST   = 16'h0000;
    localparam logic [1:0]  ADCCT_MCGEN_RST  = 2'h0;
    localparam logic [7:0]  ADCCT_IMPDIV_RST = 8'h01;

    // Conversion phase lengths in basic clock periods
    localparam logic [6:0] ADCCT_DET10_PC    = 7'd52;
    localparam logic [6:0] ADCCT_DET8_PC     = 7'd44;
    localparam logic [6:0] ADCCT_PC_SAVING   = 7'd12;
    // Result load step in system clock periods
    localparam logic [2:0] ADCCT_LOAD_SYS    = 3'd6;

    // Reset calibration bounds in basic clock periods
    localparam int ADCCT_CAL_MIN_BC = 484;
    localparam int ADCCT_CAL_MAX_BC = 11696;

    // Result codes at the input range limits
    localparam logic [9:0] ADCCT_RES_ZERO = 10'h000;
    localparam logic [9:0] ADCCT_RES_FULL = 10'h3FF;

    // AXI response codes
    localparam logic [1:0] ADCCT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ADCCT_RESP_SLVERR = 2'h2;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ADCCT_ST_IDLE   = 2'b00,
        ADCCT_ST_SAMPLE = 2'b01,
        ADCCT_ST_DETERM = 2'b10,
        ADCCT_ST_LOAD   = 2'b11
    } adcct_state_t;

endpackage

// File: dv/adcct_ain_src.sv
// Analog input source and reference model facing the converter
`timescale 1ns/1ps
module adcct_ain_src (
    input  wire logic        aclk,
    input  wire logic [11:0] set_in,
    input  wire logic        settle_in,
    output logic [9:0]       ain_level,
    output logic             ain_below_ground,
    output logic             ain_above_ref,
    output logic             ref_settled
);
    // Present the requested level and range flags
    always_ff @(posedge aclk) begin
        {ain_below_ground, ain_above_ref, ain_level} <= set_in;
    end
    // Reference settles once the bench declares it quiet
    always_ff @(posedge aclk) begin
        ref_settled <= settle_in;
    end
endmodule

// File: dv/adcct_sva.sv
// Port-level checker for the converter timing block
`timescale 1ns/1ps
module adcct_sva
    import adcct_pkg::*;
#(
    parameter int CAL_MIN_BC = 4,
    parameter int CAL_MAX_BC = 20
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       cpu_clock_tick,
    input wire logic       sys_clock_tick,
    input wire logic       basic_clock_tick,
    input wire logic       conv_done,
    input wire logic       conv_busy,
    input wire logic       cal_active,
    input wire logic [9:0] conv_result
);
    int cal_cnt; // Calibration basic ticks seen outside conversions

    // Mirror the calibration progress count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_cnt <= 0;
        end else if (cal_active && basic_clock_tick && !conv_busy) begin
            cal_cnt <= cal_cnt + 1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Busy then idle marks the end of a conversion
    sequence s_conv_end;
        conv_busy ##1 !conv_busy;
    endsequence

    chk_sys_cpu: assert property (sys_clock_tick == cpu_clock_tick)
        else $error("system tick differs from cpu tick");
    chk_cpu_half: assert property (!cpu_clock_tick |=> cpu_clock_tick)
        else $error("cpu tick missing two cycles running");
    chk_basic_sys: assert property (basic_clock_tick |-> sys_clock_tick)
        else $error("basic tick without system tick");
    chk_done_pulse: assert property (conv_done |=> !conv_done)
        else $error("done longer than one cycle");
    chk_end_done: assert property (s_conv_end |-> conv_done)
        else $error("conversion ended without done");
    chk_result_hold: assert property (!conv_done |-> $stable(conv_result))
        else $error("result moved without done");
    chk_cal_once: assert property (!cal_active |=> !cal_active)
        else $error("calibration restarted");
    chk_cal_min: assert property ($fell(cal_active) |-> cal_cnt >= CAL_MIN_BC)
        else $error("calibration ended too early");
    chk_cal_max: assert property (cal_active |-> cal_cnt <= CAL_MAX_BC)
        else $error("calibration ran too long");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    cover property (conv_busy ##1 conv_done);
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the converter timing block
`timescale 1ns/1ps
module tb_top;
    import adcct_pkg::*;
    localparam int CMIN = 4;  // Short calibration bounds
    localparam int CMAX = 20;
    typedef struct {logic [15:0] ctrl; logic [11:0] ain; logic [9:0] res;
                    int dv; int bcs;} adcct_row_t;
    adcct_row_t  rows [5];         // Conversion cases
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] ain_set = 12'h000; // Range flags and level
    logic        settle = 1'b1;     // Reference quiet
    logic        awready, wready, bvalid, arready, rvalid, cpu_t, sys_t, bc_t, done, busy, cal;
    logic        below, above, ref_ok;
    logic [1:0]  bresp, rresp, mcs, rsp;
    logic [31:0] rdata, rd;
    logic [9:0]  lvl, res;
    int          err_total = 0, checks_done = 0, cyc = 0, n, t, i;

    always #5 aclk = ~aclk;

    adcct_top #(.CAL_MIN_BC(CMIN), .CAL_MAX_BC(CMAX)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ain_level(lvl),
        .ain_below_ground(below), .ain_above_ref(above), .ref_settled(ref_ok),
        .cpu_clock_tick(cpu_t), .sys_clock_tick(sys_t), .basic_clock_tick(bc_t),
        .master_clock_source(mcs), .conv_done(done), .conv_busy(busy),
        .cal_active(cal), .conv_result(res));

    adcct_ain_src u_src (.aclk(aclk), .set_in(ain_set), .settle_in(settle), .ain_level(lvl),
        .ain_below_ground(below), .ain_above_ref(above), .ref_settled(ref_ok));

    // Value comparison
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Range comparison on bench counts
    task automatic rng(input string nm, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    // Verdict and end of run
    task automatic close_out;
        $display("Checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Register write, both halves offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp; bready <= 1'b0; break;
            end
        end
    endtask
    // Register read
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata; rsp = rresp; rready <= 1'b0; break;
            end
        end
    endtask
    // Reset for ten cycles with a chosen reference state
    task automatic do_reset(input logic s);
        aresetn <= 1'b0; settle <= s;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Count calibration ticks outside conversions until it ends
    task automatic cal_wait(output int c);
        c = 0;
        for (int k = 0; k < 5000 && cal; k++) begin
            @(posedge aclk);
            if (cal && bc_t && !busy) c++;
        end
    endtask
    // Wait for done under a bound
    task automatic wait_done;
        t = 0;
        while (done !== 1'b1 && t < 3000) begin
            @(posedge aclk); t++;
        end
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        rows[0] = '{16'h0001, 12'h2A5, 10'h2A5, 4, 60};  // /4, 8 samples, 10-bit
        rows[1] = '{16'h5003, 12'h2A7, 10'h2A4, 2, 60};  // /2, 16 samples, 8-bit
        rows[2] = '{16'hA005, 12'h955, 10'h000, 16, 72}; // /16, 32 samples, below ground
        rows[3] = '{16'hF007, 12'h4AA, 10'h3FF, 8, 96};  // /8, 64 samples, above reference
        rows[4] = '{16'h0001, 12'hC3C, 10'h000, 4, 60};  // Both flags, ground wins
        do_reset(1'b1);
        chk("cal after reset", 32'h1, {31'h0, cal});
        cal_wait(n);
        rng("cal min ticks", CMIN, CMIN + 1, n);
        rd_reg(ADCCT_OFF_IMPDIV);
        chk("impdiv reset", 32'h1, rd);
        rd_reg(8'h18);
        chk("unmapped resp", {30'h0, ADCCT_RESP_SLVERR}, {30'h0, rsp});
        // Table of conversions
        for (i = 0; i < 5; i++) begin
            ain_set <= rows[i].ain;
            repeat (4) @(posedge aclk);
            wr(ADCCT_OFF_CTRL, {16'h0, rows[i].ctrl});
            wait_done();
            n = rows[i].dv * rows[i].bcs;
            rng("conv cycles", n - rows[i].dv + 3, n + 9, t);
            chk("result port", {22'h0, rows[i].res}, {22'h0, res});
            rd_reg(ADCCT_OFF_RESULT);
            chk("result reg", {22'h0, rows[i].res}, rd);
        end
        rd_reg(ADCCT_OFF_STATUS);
        chk("status idle", 32'h4, rd);
        // Clock halving and master clock source
        wr(ADCCT_OFF_SYSCFG, 32'h1);
        wr(ADCCT_OFF_MCGEN, 32'h2);
        chk("write resp", {30'h0, ADCCT_RESP_OKAY}, {30'h0, rsp});
        chk("clock source", 32'h2, {30'h0, mcs});
        n = 0;
        repeat (20) begin
            @(posedge aclk); n += cpu_t;
        end
        rng("cpu ticks", 10, 10, n);
        wr(ADCCT_OFF_SYSCFG, 32'h0);
        // Improved divider mode
        wr(ADCCT_OFF_IMPDIV, 32'h3);
        wr(ADCCT_OFF_CTRL, 32'h8);
        n = 0;
        repeat (30) begin
            @(posedge aclk); n += bc_t;
        end
        rng("improved ticks", 10, 10, n);
        wr(ADCCT_OFF_CTRL, 32'h0);
        // Conversion inside an unsettled calibration
        do_reset(1'b0);
        wr(ADCCT_OFF_CTRL, 32'h1);
        wait_done();
        chk("cal during conv", 32'h1, {31'h0, cal});
        cal_wait(n);
        rng("cal max ticks", CMAX - 2, CMAX + 1, n);
        close_out();
    end
endmodule

bind adcct_top adcct_sva #(.CAL_MIN_BC(CAL_MIN_BC), .CAL_MAX_BC(CAL_MAX_BC)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .cpu_clock_tick(cpu_clock_tick), .sys_clock_tick(sys_clock_tick),
    .basic_clock_tick(basic_clock_tick), .conv_done(conv_done), .conv_busy(conv_busy),
    .cal_active(cal_active), .conv_result(conv_result));

// File: verilog/adcct_top.sv
// Converter clocking, conversion sequencer, reset calibration and register slave
`timescale 1ns/1ps
module adcct_top
    import adcct_pkg::*;
#(
    parameter int CAL_MIN_BC = ADCCT_CAL_MIN_BC, // Shortest calibration, basic periods
    parameter int CAL_MAX_BC = ADCCT_CAL_MAX_BC  // Longest calibration, basic periods
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [9:0]  ain_level,
    input  wire logic        ain_below_ground,
    input  wire logic        ain_above_ref,
    input  wire logic        ref_settled,
    output logic             cpu_clock_tick,
    output logic             sys_clock_tick,
    output logic             basic_clock_tick,
    output logic [1:0]       master_clock_source,
    output logic             conv_done,
    output logic             conv_busy,
    output logic             cal_active,
    output logic [9:0]       conv_result
);

    // Software-visible configuration
    logic [15:0]  converter_control_register; // Divider, sample time, mode bits
    logic         cpu_clock_halving_select;   // Halves CPU and system clock
    logic [1:0]   master_clock_generator_control; // Master clock source
    logic [7:0]   improved_divider;           // Divider used in improved mode
    logic         result_valid;               // Set on load, cleared by start
    logic         start_pulse;                // One-cycle start from a write

    // Analog input synchronisers
    logic [12:0]  ain_meta;                   // First stage only
    logic [12:0]  ain_sync;                   // Second stage, safe to use

    // Clock derivation
    logic         half_phase;                 // Toggles every cycle, used only when halving
    logic [7:0]   bc_count;                   // System ticks within a basic period
    logic [7:0]   bc_divisor;                 // Selected division factor

    // Sequencer
    adcct_state_t state;                      // Current conversion phase
    adcct_state_t next_state;                 // Phase for the next cycle
    logic [6:0]   phase_count;                // Basic or system periods elapsed
    logic [6:0]   sample_len;                 // Sample phase length
    logic [6:0]   determ_len;                 // Result determination length
    logic [9:0]   sampled_code;               // Code captured at sample end

    // Calibration
    logic [13:0]  cal_count;                  // Basic periods of calibration done

    // AXI write side holding registers
    logic         aw_held;
    logic [7:0]   aw_addr;
    logic         w_held;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;

    // Basic clock division factor for a compatibility code
    function automatic logic [7:0] div_of(input logic [1:0] code);
        case (code)
            2'b00:   div_of = 8'h04;
            2'b01:   div_of = 8'h02;
            2'b10:   div_of = 8'h10;
            default: div_of = 8'h08;
        endcase
    endfunction

    // Sample phase length for a sample time code
    function automatic logic [6:0] sample_of(input logic [1:0] code);
        case (code)
            2'b00:   sample_of = 7'd8;
            2'b01:   sample_of = 7'd16;
            2'b10:   sample_of = 7'd32;
            default: sample_of = 7'd64;
        endcase
    endfunction

    // Address decode shared by both bus directions
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == ADCCT_OFF_CTRL)   || (addr == ADCCT_OFF_STATUS) ||
                    (addr == ADCCT_OFF_RESULT) || (addr == ADCCT_OFF_SYSCFG) ||
                    (addr == ADCCT_OFF_MCGEN)  || (addr == ADCCT_OFF_IMPDIV);
    endfunction

    // Two-flop synchroniser for the analog front-end levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ain_meta <= 13'h0000;
            ain_sync <= 13'h0000;
        end else begin
            ain_meta <= {ref_settled, ain_above_ref, ain_below_ground, ain_level};
            ain_sync <= ain_meta;
        end
    end

    // CPU clock rate: every cycle or every second cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= ~half_phase;
        end
    end

    // CPU tick follows the halving bit; system tick runs at the same rate
    assign cpu_clock_tick = cpu_clock_halving_select ? half_phase : 1'b1;
    assign sys_clock_tick = cpu_clock_tick;
    assign master_clock_source = master_clock_generator_control;

    // Divisor from the table, or from the improved divider register
    always_comb begin
        if (converter_control_register[ADCCT_CTRL_IMPR_BIT]) begin
            bc_divisor = (improved_divider == 8'h00) ? 8'h01 : improved_divider;
        end else begin
            bc_divisor = div_of(converter_control_register[ADCCT_CTRL_CTC_LSB +: 2]);
        end
    end

    // Basic clock: one tick each divisor system ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bc_count <= 8'h00;
        end else if (sys_clock_tick) begin
            if (bc_count + 8'h01 >= bc_divisor) begin
                bc_count <= 8'h00;
            end else begin
                bc_count <= bc_count + 8'h01;
            end
        end
    end

    assign basic_clock_tick = sys_clock_tick && (bc_count + 8'h01 >= bc_divisor);

    // Phase lengths chosen from the control register
    always_comb begin
        sample_len = sample_of(converter_control_register[ADCCT_CTRL_STC_LSB +: 2]);
        determ_len = converter_control_register[ADCCT_CTRL_RES8_BIT] ?
                     ADCCT_DET8_PC : ADCCT_DET10_PC;
        if (converter_control_register[ADCCT_CTRL_NOPC_BIT]) begin
            determ_len = determ_len - ADCCT_PC_SAVING;
        end
    end

    // Sequencer next-state logic
    always_comb begin
        next_state = state;
        case (state)
            ADCCT_ST_IDLE: begin
                if (start_pulse) begin
                    next_state = ADCCT_ST_SAMPLE;
                end
            end
            ADCCT_ST_SAMPLE: begin
                // Sample phase ends after its basic periods
                if (basic_clock_tick && phase_count + 7'd1 >= sample_len) begin
                    next_state = ADCCT_ST_DETERM;
                end
            end
            ADCCT_ST_DETERM: begin
                // Determination ends after its basic periods
                if (basic_clock_tick && phase_count + 7'd1 >= determ_len) begin
                    next_state = ADCCT_ST_LOAD;
                end
            end
            ADCCT_ST_LOAD: begin
                // Result load takes six system periods
                if (sys_clock_tick && phase_count + 7'd1 >= {4'h0, ADCCT_LOAD_SYS}) begin
                    next_state = ADCCT_ST_IDLE;
                end
            end
            default: begin
                next_state = ADCCT_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ADCCT_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter: restarts on each phase change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_count <= 7'd0;
        end else if (next_state != state) begin
            phase_count <= 7'd0;
        end else if (state == ADCCT_ST_LOAD) begin
            if (sys_clock_tick) begin
                phase_count <= phase_count + 7'd1;
            end
        end else if (state != ADCCT_ST_IDLE && basic_clock_tick) begin
            phase_count <= phase_count + 7'd1;
        end
    end

    // Capture the clamped code when sampling ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sampled_code <= ADCCT_RES_ZERO;
        end else if (state == ADCCT_ST_SAMPLE && next_state == ADCCT_ST_DETERM) begin
            if (ain_sync[10]) begin
                sampled_code <= ADCCT_RES_ZERO;
            end else if (ain_sync[11]) begin
                sampled_code <= ADCCT_RES_FULL;
            end else if (converter_control_register[ADCCT_CTRL_RES8_BIT]) begin
                sampled_code <= {ain_sync[9:2], 2'b00};
            end else begin
                sampled_code <= ain_sync[9:0];
            end
        end
    end

    // Result register and done pulse at the end of the load step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_result <= ADCCT_RES_ZERO;
            conv_done   <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (state == ADCCT_ST_LOAD && next_state == ADCCT_ST_IDLE) begin
                conv_result <= sampled_code;
                conv_done   <= 1'b1;
            end
        end
    end

    // Valid flag: load sets, a new start clears, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_valid <= 1'b0;
        end else if (state == ADCCT_ST_LOAD && next_state == ADCCT_ST_IDLE) begin
            result_valid <= 1'b1;
        end else if (start_pulse) begin
            result_valid <= 1'b0;
        end
    end

    assign conv_busy = (state != ADCCT_ST_IDLE);

    // Reset calibration: pauses while a conversion runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_active <= 1'b1;
            cal_count  <= 14'd0;
        end else if (cal_active && !conv_busy && basic_clock_tick) begin
            cal_count <= cal_count + 14'd1;
            if ((int'(cal_count) + 1 >= CAL_MIN_BC && ain_sync[12]) ||
                int'(cal_count) + 1 >= CAL_MAX_BC) begin
                cal_active <= 1'b0;
            end
        end
    end

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    // Hold write address and data until both are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Write response once both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ADCCT_RESP_OKAY;
        end else if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? ADCCT_RESP_OKAY : ADCCT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes and the start strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_control_register     <= ADCCT_CTRL_RST;
            cpu_clock_halving_select       <= 1'b0;
            master_clock_generator_control <= ADCCT_MCGEN_RST;
            improved_divider               <= ADCCT_IMPDIV_RST;
            start_pulse                    <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            if (aw_held && w_held) begin
                case (aw_addr)
                    ADCCT_OFF_CTRL: begin
                        if (w_strb[0]) begin
                            converter_control_register[7:1] <= w_data[7:1];
                            // Start ignored while a conversion runs
                            start_pulse <= w_data[ADCCT_CTRL_START_BIT] && !conv_busy;
                        end
                        if (w_strb[1]) begin
                            converter_control_register[15:8] <= w_data[15:8];
                        end
                    end
                    ADCCT_OFF_SYSCFG: begin
                        if (w_strb[0]) begin
                            cpu_clock_halving_select <= w_data[0];
                        end
                    end
                    ADCCT_OFF_MCGEN: begin
                        if (w_strb[0]) begin
                            master_clock_generator_control <= w_data[1:0];
                        end
                    end
                    ADCCT_OFF_IMPDIV: begin
                        if (w_strb[0]) begin
                            improved_divider <= w_data[7:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read channel: one-cycle answer, one read at a time
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ADCCT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped({s_axi_araddr[7:2], 2'b00}) ?
                            ADCCT_RESP_OKAY : ADCCT_RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                ADCCT_OFF_CTRL:   s_axi_rdata <= {16'h0000, converter_control_register[15:1],
                                                  1'b0};
                ADCCT_OFF_STATUS: s_axi_rdata <= {29'h0000_0000, result_valid, cal_active,
                                                  conv_busy};
                ADCCT_OFF_RESULT: s_axi_rdata <= {22'h00_0000, conv_result};
                ADCCT_OFF_SYSCFG: s_axi_rdata <= {31'h0000_0000, cpu_clock_halving_select};
                ADCCT_OFF_MCGEN:  s_axi_rdata <= {30'h0000_0000,
                                                  master_clock_generator_control};
                ADCCT_OFF_IMPDIV: s_axi_rdata <= {24'h00_0000, improved_divider};
                default:          s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
